// >>> rtl/t1_rx_alarm_status_monitor.sv
`timescale 1ns/100ps
`include "t1_rx_mon_defs.svh"
module t1_rx_alarm_status_monitor #(
	parameter int WIN_BITS = `T_WIN_US * `LINE_KHZ / 1000,
	parameter int BLUE_BITS = `T_BLUE_US * `LINE_KHZ / 1000,
	parameter int HALF_BITS = `T_HALF_US * `LINE_KHZ / 1000,
	parameter int LOS_CYC = `T_LOS_US * `CLK_KHZ / 1000
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic cs_n_i,
	input wire logic rd_n_i,
	input wire t1_rx_mon_pkg::reg_addr_t addr_i,
	output t1_rx_mon_pkg::reg_byte_t rdata_o,
	output logic rdata_oe_o,
	input wire logic rx_bit_stb_i,
	input wire logic rx_bit_i,
	input wire logic rx_ch_bit2_stb_i,
	input wire logic rx_s12_stb_i,
	input wire logic rx_dl_stb_i,
	input wire logic zero_substitution_enable_i,
	input wire logic rx_slip_i,
	input wire logic rx_slip_repeat_i,
	input wire logic rx_frame_depth_i,
	input wire logic [2:0] rx_sub_bit_delay_i,
	input wire logic [4:0] rx_slot_delay_i,
	input wire logic [2:0] rx_bit_delay_i,
	input wire logic line_level_low_i
);
	import t1_rx_mon_pkg::*;

	localparam int PH_BITS = `T_PHASE_US * `LINE_KHZ / 1000;
	localparam int YEL_SET_WIN = (`T_YEL_SET_MS + `T_WIN_MS - 1) / `T_WIN_MS;
	localparam int YEL_CLR_WIN = (`T_YEL_CLR_MS + `T_WIN_MS - 1) / `T_WIN_MS;
	localparam int NMAX = 23;
	localparam int HLEN = 8 * (NMAX + 1);

	// ==========================================
	// state
	typedef struct packed {
		logic cs_m, cs_s, rd_m, rd_s, los_m, los_s;
		reg_addr_t addr_m, addr_s;
		reg_byte_t rdata;
		logic oe;
		logic [19:0] win_cnt, blue_cnt, half_cnt, ph_cnt, los_cnt;
		logic [4:0] y_ones;
		logic [3:0] y_set, y_clr;
		logic sf_long, sf_samp, sec, esf, blue, ones_density_violation, lu, ld;
		logic s12_prev;
		logic [15:0] dl_sr;
		logic [3:0] dl_cnt;
		logic [9:0] esf_hist;
		logic [9:0][8:0] bom_hist;
		reg_byte_t bom;
		logic [2:0] zeros;
		logic [4:0] zrun;
		logic [HLEN-1:0] hist;
		logic [NMAX-1:0][7:0] wcnt;
		logic viol;
		logic [4:0] loop_sr, lu_err, ld_err;
		logic t_half, t_one, t_two5;
		logic [2:0] halves;
		logic slip, dir, frm, wink;
		logic [2:0] sbd, bitc;
		logic [4:0] slot;
		logic lost;
	} state_s;

	state_s q_r, q_nxt;

	// ==========================================
	// density windows, one running ones count per N
	logic [NMAX-1:0][7:0] wcnt_w;
	logic [NMAX-1:0] thin_w;
	logic [9:0] bom_eq_w;
	logic [15:0] word_w;

	assign word_w = {q_r.dl_sr[14:0], rx_bit_i};

	genvar gi;
	generate
		for (gi = 0; gi < NMAX; gi++) begin : g_win
			assign wcnt_w[gi] = rx_bit_stb_i ?
				8'(q_r.wcnt[gi] + {7'h00, rx_bit_i} - {7'h00, q_r.hist[8*(gi+2)-1]}) :
				q_r.wcnt[gi];
			assign thin_w[gi] = wcnt_w[gi] < 8'(gi + 1);
		end
		for (gi = 0; gi < 10; gi++) begin : g_bom
			assign bom_eq_w[gi] = q_r.bom_hist[gi][8] &&
				q_r.bom_hist[gi][7:0] == word_w[7:0];
		end
	endgenerate

	// ==========================================
	// next state
	always_comb begin
		logic win_end, bomw, yelw, wdone;
		logic [4:0] zr;
		reg_byte_t b;
		q_nxt = q_r;
		win_end = rx_bit_stb_i && q_r.win_cnt == 20'(WIN_BITS - 1);
		zr = q_r.zrun;
		b = 8'h00;
		yelw = word_w == `ESF_YEL_CODE;
		// a zero message byte would alias the yellow stream shifted by eight bits
		bomw = word_w[15:8] == 8'hFF && !word_w[7] && !word_w[0] &&
			word_w[7:0] != 8'h00;
		wdone = 1'b0;

		// pins pass two flops before use
		q_nxt.cs_m = cs_n_i;
		q_nxt.cs_s = q_r.cs_m;
		q_nxt.rd_m = rd_n_i;
		q_nxt.rd_s = q_r.rd_m;
		q_nxt.addr_m = addr_i;
		q_nxt.addr_s = q_r.addr_m;
		q_nxt.los_m = line_level_low_i;
		q_nxt.los_s = q_r.los_m;

		if (rx_bit_stb_i) begin
			q_nxt.win_cnt = win_end ? 20'h00000 : 20'(q_r.win_cnt + 1);
			q_nxt.blue_cnt = (q_r.blue_cnt == 20'(BLUE_BITS - 1)) ? 20'h00000 :
				20'(q_r.blue_cnt + 1);
			q_nxt.half_cnt = (q_r.half_cnt == 20'(HALF_BITS - 1)) ? 20'h00000 :
				20'(q_r.half_cnt + 1);
			q_nxt.ph_cnt = (q_r.ph_cnt == 20'(PH_BITS - 1)) ? 20'h00000 :
				20'(q_r.ph_cnt + 1);
		end

		// ones in bit 2, saturating just past the limit
		if (rx_ch_bit2_stb_i && rx_bit_i && q_r.y_ones <= 5'(`YEL_ONES_MAX))
			q_nxt.y_ones = 5'(q_r.y_ones + 1);
		if (win_end) begin
			q_nxt.sf_samp = q_r.y_ones <= 5'(`YEL_ONES_MAX);
			q_nxt.y_ones = 5'h00;
			if (q_nxt.sf_samp) begin
				q_nxt.y_clr = 4'h0;
				if (q_r.y_set < 4'(YEL_SET_WIN))
					q_nxt.y_set = 4'(q_r.y_set + 1);
				if (q_nxt.y_set >= 4'(YEL_SET_WIN))
					q_nxt.sf_long = 1'b1;
			end else begin
				q_nxt.y_set = 4'h0;
				if (q_r.y_clr < 4'(YEL_CLR_WIN))
					q_nxt.y_clr = 4'(q_r.y_clr + 1);
				if (q_nxt.y_clr >= 4'(YEL_CLR_WIN))
					q_nxt.sf_long = 1'b0;
			end
		end

		if (rx_s12_stb_i) begin
			q_nxt.sec = q_r.s12_prev && rx_bit_i;
			q_nxt.s12_prev = rx_bit_i;
		end

		// codeword positions realign on any recognised codeword
		if (rx_dl_stb_i) begin
			q_nxt.dl_sr = word_w;
			wdone = q_r.dl_cnt == 4'hF || yelw || bomw;
			q_nxt.dl_cnt = wdone ? 4'h0 : 4'(q_r.dl_cnt + 1);
		end
		if (wdone) begin
			q_nxt.esf_hist = {q_r.esf_hist[8:0], yelw};
			q_nxt.esf = $countones(q_nxt.esf_hist) >= `ESF_YEL_MIN;
			q_nxt.bom_hist = {q_r.bom_hist[8:0], {bomw, word_w[7:0]}};
			// eight of ten, the newest included
			if (bomw && 4'($countones(bom_eq_w[8:0])) + 4'h1 >= 4'(`BOM_MIN))
				q_nxt.bom = word_w[7:0];
		end

		if (rx_bit_stb_i) begin
			if (!rx_bit_i && q_r.zeros < 3'(`BLUE_ZEROS_MIN))
				q_nxt.zeros = 3'(q_r.zeros + 1);
			if (q_r.blue_cnt == 20'(BLUE_BITS - 1)) begin
				q_nxt.blue = q_nxt.zeros < 3'(`BLUE_ZEROS_MIN);
				q_nxt.zeros = 3'h0;
			end
			zr = rx_bit_i ? 5'h00 : (q_r.zrun == 5'h1F ? 5'h1F : 5'(q_r.zrun + 1));
			q_nxt.zrun = zr;
			q_nxt.hist = {q_r.hist[HLEN-2:0], rx_bit_i};
			q_nxt.wcnt = wcnt_w;
			if (zero_substitution_enable_i)
				q_nxt.viol = zr == 5'(`PDV_RUN_ZS);
			else
				q_nxt.viol = zr == 5'(`PDV_RUN) || |thin_w;
			// one toggle per violation episode
			if (q_nxt.viol && !q_r.viol)
				q_nxt.ones_density_violation = !q_r.ones_density_violation;
		end

		// loop codes: a mismatch against the bit one period back is an error
		if (rx_bit_stb_i) begin
			q_nxt.loop_sr = {q_r.loop_sr[3:0], rx_bit_i};
			if (rx_bit_i != q_r.loop_sr[4] && q_r.lu_err != 5'h1F)
				q_nxt.lu_err = 5'(q_r.lu_err + 1);
			if (rx_bit_i != q_r.loop_sr[2] && q_r.ld_err != 5'h1F)
				q_nxt.ld_err = 5'(q_r.ld_err + 1);
		end
		if (win_end) begin
			q_nxt.lu = q_r.lu_err <= 5'(`LOOP_ERR_MAX) &&
				$countones(q_nxt.loop_sr) == 1;
			q_nxt.ld = q_r.ld_err <= 5'(`LOOP_ERR_MAX) &&
				$countones(q_nxt.loop_sr[2:0]) == 1;
			q_nxt.lu_err = 5'h00;
			q_nxt.ld_err = 5'h00;
		end

		if (rx_bit_stb_i && q_r.half_cnt == 20'(HALF_BITS - 1)) begin
			q_nxt.t_half = !q_r.t_half;
			q_nxt.halves = (q_r.halves == 3'(`TWO5_TIMER_HALVES - 1)) ? 3'h0 :
				3'(q_r.halves + 1);
			if (q_r.t_half)
				q_nxt.t_one = !q_r.t_one;
			if (q_r.halves == 3'(`TWO5_TIMER_HALVES - 1))
				q_nxt.t_two5 = !q_r.t_two5;
		end

		if (rx_slip_i) begin
			q_nxt.slip = !q_r.slip;
			q_nxt.dir = rx_slip_repeat_i;
		end

		if (rx_bit_stb_i && q_r.ph_cnt == 20'(PH_BITS - 1)) begin
			q_nxt.frm = rx_frame_depth_i;
			q_nxt.sbd = rx_sub_bit_delay_i;
			q_nxt.slot = rx_slot_delay_i;
			q_nxt.bitc = rx_bit_delay_i;
			// a fall and rise between two refreshes goes unseen
			// wink on slot msb fall
			if (q_r.slot[4] && !rx_slot_delay_i[4])
				q_nxt.wink = !q_r.wink;
		end

		if (!q_r.los_s)
			q_nxt.los_cnt = 20'h00000;
		else if (q_r.los_cnt != 20'(LOS_CYC))
			q_nxt.los_cnt = 20'(q_r.los_cnt + 1);
		q_nxt.lost = q_nxt.los_cnt == 20'(LOS_CYC);

		q_nxt.oe = !q_r.cs_s && !q_r.rd_s;
		if (q_nxt.oe) begin
			if (q_r.addr_s == `ADDR_ALARM) begin
				b[`ALM_SF_LONG] = q_r.sf_long;
				b[`ALM_SF_SAMP] = q_r.sf_samp;
				b[`ALM_SEC] = q_r.sec;
				b[`ALM_ESF] = q_r.esf;
				b[`ALM_BLUE] = q_r.blue;
				b[`ALM_PDV] = q_r.ones_density_violation;
				b[`ALM_LOOP_UP] = q_r.lu;
				b[`ALM_LOOP_DN] = q_r.ld;
			end else if (q_r.addr_s == `ADDR_TIMER) begin
				b[`TMR_HALF] = q_r.t_half;
				b[`TMR_ONE] = q_r.t_one;
				b[`TMR_TWO5] = q_r.t_two5;
			end else if (q_r.addr_s == `ADDR_PH_UP) begin
				b[`PHU_SLIP] = q_r.slip;
				b[`PHU_DIR] = q_r.dir;
				b[`PHU_FRM] = q_r.frm;
				b[`PHU_WINK] = q_r.wink;
				b[2:0] = q_r.sbd;
			end else if (q_r.addr_s == `ADDR_PH_LO) begin
				b = {q_r.slot, q_r.bitc};
			end else if (q_r.addr_s == `ADDR_MSG) begin
				b = q_r.bom;
			end else if (q_r.addr_s == `ADDR_SIG) begin
				b[`SIG_LOST] = q_r.lost;
			end
			q_nxt.rdata = b;
		end
	end

	// ==========================================
	// registers
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			q_r <= '0;
			q_r.cs_m <= 1'b1;
			q_r.cs_s <= 1'b1;
			q_r.rd_m <= 1'b1;
			q_r.rd_s <= 1'b1;
			q_r.rdata <= `RDATA_RST;
			// history starts dense so no false density alarm after reset
			q_r.hist <= '1;
			for (int n = 0; n < NMAX; n++) begin
				q_r.wcnt[n] <= 8'(8 * (n + 2));
			end
		end else begin
			q_r <= q_nxt;
		end
	end

	assign rdata_o = q_r.rdata;
	assign rdata_oe_o = q_r.oe;

endmodule : t1_rx_alarm_status_monitor

// >>> rtl/t1_rx_mon_defs.svh
`ifndef T1_RX_MON_DEFS_SVH
`define T1_RX_MON_DEFS_SVH
// ==========================================
// register offsets
`define ADDR_ALARM 5'h11
`define ADDR_TIMER 5'h12
`define ADDR_PH_UP 5'h13
`define ADDR_PH_LO 5'h14
`define ADDR_MSG 5'h15
`define ADDR_SIG 5'h16
`define RDATA_RST 8'h00
// ==========================================
// field positions
`define ALM_SF_LONG 7
`define ALM_SF_SAMP 6
`define ALM_SEC 5
`define ALM_ESF 4
`define ALM_BLUE 3
`define ALM_PDV 2
`define ALM_LOOP_UP 1
`define ALM_LOOP_DN 0
`define TMR_HALF 7
`define TMR_ONE 6
`define TMR_TWO5 5
`define PHU_SLIP 7
`define PHU_DIR 6
`define PHU_FRM 5
`define PHU_WINK 3
`define SIG_LOST 7
// ==========================================
// rates and times
`define LINE_KHZ 1544
`define CLK_KHZ 10000
`define T_WIN_US 48000
`define T_BLUE_US 3000
`define T_HALF_US 500000
`define T_PHASE_US 250
`define T_LOS_US 1000
`define T_WIN_MS 48
`define T_YEL_SET_MS 600
`define T_YEL_CLR_MS 200
// ==========================================
// thresholds and codes
`define YEL_ONES_MAX 16
`define LOOP_ERR_MAX 15
`define BLUE_ZEROS_MIN 6
`define ESF_YEL_CODE 16'h00FF
`define ESF_YEL_MIN 7
`define BOM_MIN 8
`define PDV_RUN_ZS 8
`define PDV_RUN 16
`define ONE_TIMER_HALVES 2
`define TWO5_TIMER_HALVES 5
`endif

// >>> rtl/t1_rx_mon_pkg.sv
package t1_rx_mon_pkg;
	typedef logic [4:0] reg_addr_t;
	typedef logic [7:0] reg_byte_t;
endpackage : t1_rx_mon_pkg

// >>> tb/t1_rx_mon_properties.sv
`timescale 1ns/100ps
// ==========================================
// read port checker
module t1_rx_mon_chk (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic cs_n_i,
	input wire logic rd_n_i,
	input wire t1_rx_mon_pkg::reg_addr_t addr_i,
	input wire t1_rx_mon_pkg::reg_byte_t rdata_o,
	input wire logic rdata_oe_o,
	input wire logic line_level_low_i
);
	import t1_rx_mon_pkg::*;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	sequence s_rd_any;
		(!cs_n_i && !rd_n_i)[*4];
	endsequence
	sequence s_rd(logic [4:0] a);
		(!cs_n_i && !rd_n_i && addr_i == a)[*4];
	endsequence
	property p_oe_on; s_rd_any |-> rdata_oe_o; endproperty
	a_oe_on: assert property (p_oe_on) else $error("read data not driven");
	property p_oe_off; (cs_n_i || rd_n_i)[*4] |-> !rdata_oe_o; endproperty
	a_oe_off: assert property (p_oe_off) else $error("read data driven idle");
	property p_oe_cause; $rose(rdata_oe_o) |-> $past(!cs_n_i && !rd_n_i, 3); endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("read data early");
	// no side effects: output moves only while read
	property p_hold; !rdata_oe_o && $past(!rdata_oe_o) |-> $stable(rdata_o); endproperty
	a_hold: assert property (p_hold) else $error("read data moved idle");
	property p_unmapped; s_rd(5'h1F) |-> rdata_o == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_tmr_pad; s_rd(5'h12) |-> rdata_o[4:0] == 5'h00; endproperty
	a_tmr_pad: assert property (p_tmr_pad) else $error("timer pad bits set");
	property p_sig_pad; s_rd(5'h16) |-> rdata_o[6:0] == 7'h00; endproperty
	a_sig_pad: assert property (p_sig_pad) else $error("signal pad bits set");
	property p_los_off; (!line_level_low_i)[*8] ##0 s_rd(5'h16) |-> !rdata_o[7]; endproperty
	a_los_off: assert property (p_los_off) else $error("loss bit with good level");
endmodule : t1_rx_mon_chk
bind t1_rx_alarm_status_monitor t1_rx_mon_chk chk_u (.clk_sys_i, .rst_i, .cs_n_i,
	.rd_n_i, .addr_i, .rdata_o, .rdata_oe_o, .line_level_low_i);

// >>> tb/t1_line_far_end.sv
`timescale 1ns/100ps
// ==========================================
// far line terminal: line bits, channel bit 2, frame-12 s-bit, data link
module t1_line_far_end (
	input wire logic clk_sys_i,
	output logic bit_stb_o,
	output logic bit_o,
	output logic ch_bit2_stb_o,
	output logic s12_stb_o,
	output logic dl_stb_o
);
	initial begin
		bit_stb_o = 1'b0;
		bit_o = 1'b0;
		ch_bit2_stb_o = 1'b0;
		s12_stb_o = 1'b0;
		dl_stb_o = 1'b0;
	end
	// kind 0 plain, 1 channel bit 2, 2 frame-12 s-bit, 3 data link
	task automatic send(input logic b, input int n, input int kind);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_sys_i);
			#10;
			bit_stb_o = 1'b1;
			bit_o = b;
			ch_bit2_stb_o = (kind == 1);
			s12_stb_o = (kind == 2);
			dl_stb_o = (kind == 3);
		end
		@(posedge clk_sys_i);
		#10;
		bit_stb_o = 1'b0;
		ch_bit2_stb_o = 1'b0;
		s12_stb_o = 1'b0;
		dl_stb_o = 1'b0;
		// unqualified line shows the opposite level so stale bits never pass
		bit_o = ~b;
	endtask : send
	// data-link codewords, msb first
	task automatic send_word(input logic [15:0] w, input int n);
		for (int k = 0; k < n; k++) begin
			for (int i = 15; i >= 0; i--) begin
				send(w[i], 1, 3);
			end
		end
	endtask : send_word
endmodule : t1_line_far_end

// >>> tb/testbench.sv
`timescale 1ns/100ps
module testbench;
	import t1_rx_mon_pkg::*;
	logic clk_sys_i, rst_i, cs_n, rd_n, oe, stb, bt, ch2, s12, dl, zs, slip, rep, depth, low;
	logic [2:0] sub, bitd;
	logic [4:0] slot;
	reg_addr_t addr;
	reg_byte_t rdata;
	int error_cnt = 0;
	int tests_run = 0;
	int cyc = 0;
	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	t1_rx_alarm_status_monitor #(.WIN_BITS(64), .BLUE_BITS(32), .HALF_BITS(40),
		.LOS_CYC(20)) dut_u (.clk_sys_i, .rst_i, .cs_n_i(cs_n), .rd_n_i(rd_n),
		.addr_i(addr), .rdata_o(rdata), .rdata_oe_o(oe), .rx_bit_stb_i(stb),
		.rx_bit_i(bt), .rx_ch_bit2_stb_i(ch2), .rx_s12_stb_i(s12), .rx_dl_stb_i(dl),
		.zero_substitution_enable_i(zs), .rx_slip_i(slip), .rx_slip_repeat_i(rep),
		.rx_frame_depth_i(depth), .rx_sub_bit_delay_i(sub), .rx_slot_delay_i(slot),
		.rx_bit_delay_i(bitd), .line_level_low_i(low));
	t1_line_far_end far_u (.clk_sys_i, .bit_stb_o(stb), .bit_o(bt),
		.ch_bit2_stb_o(ch2), .s12_stb_o(s12), .dl_stb_o(dl));
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 10000) begin
			error_cnt++;
			give_verdict();
		end
	end
	task automatic chk(input string nm, input reg_byte_t e, input reg_byte_t g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// address settles before the strobe; held one edge past the answer
	task automatic rc(input reg_addr_t a, input reg_byte_t m, input reg_byte_t e, string nm);
		int n;
		reg_byte_t d;
		@(posedge clk_sys_i);
		#10 addr = a;
		repeat (3) @(posedge clk_sys_i);
		#10 cs_n = 1'b0;
		rd_n = 1'b0;
		n = 0;
		d = 8'h00;
		do begin
			@(posedge clk_sys_i);
			#1 n++;
			d = rdata;
		end while (oe !== 1'b1 && n < 8);
		@(posedge clk_sys_i);
		#10 cs_n = 1'b1;
		rd_n = 1'b1;
		repeat (4) @(posedge clk_sys_i);
		#10 chk(nm, e, (oe === 1'b0 && n < 8) ? d & m : 8'hXX);
	endtask : rc
	task automatic slip_once(input logic r);
		@(posedge clk_sys_i);
		#10 rep = r;
		slip = 1'b1;
		@(posedge clk_sys_i);
		#10 slip = 1'b0;
	endtask : slip_once
	initial begin
		{cs_n, rd_n, rst_i} = 3'h7;
		{zs, slip, rep, depth, low, sub, bitd, slot, addr} = '0;
		repeat (2) @(posedge clk_sys_i);
		#10 rst_i = 1'b0;
		for (int a = 17; a < 23; a++) rc(reg_addr_t'(a), 8'hFF, 8'h00, "status reset");
		rc(5'h1F, 8'hFF, 8'h00, "unmapped");
		$display("test reset done");
		far_u.send(1'b1, 768, 0);
		rc(5'h11, 8'hC0, 8'h40, "line_alarm_flags");
		far_u.send(1'b1, 64, 0);
		rc(5'h11, 8'hC0, 8'hC0, "line_alarm_flags");
		far_u.send(1'b1, 256, 1);
		rc(5'h11, 8'hC0, 8'h80, "line_alarm_flags");
		far_u.send(1'b1, 64, 1);
		rc(5'h11, 8'hC0, 8'h00, "line_alarm_flags");
		$display("test remote alarm done");
		rc(5'h12, 8'hE0, 8'h20, "periodic_timer_flags");
		far_u.send(1'b1, 8, 0);
		rc(5'h12, 8'hE0, 8'hA0, "periodic_timer_flags");
		rc(5'h11, 8'h08, 8'h08, "line_alarm_flags");
		$display("test timers blue done");
		zs = 1'b1;
		far_u.send(1'b0, 7, 0);
		rc(5'h11, 8'h04, 8'h00, "line_alarm_flags");
		far_u.send(1'b0, 1, 0);
		rc(5'h11, 8'h04, 8'h04, "line_alarm_flags");
		far_u.send(1'b1, 20, 0);
		zs = 1'b0;
		far_u.send(1'b0, 15, 0);
		rc(5'h11, 8'h04, 8'h04, "line_alarm_flags");
		far_u.send(1'b0, 1, 0);
		rc(5'h11, 8'h04, 8'h00, "line_alarm_flags");
		far_u.send(1'b1, 1, 2);
		rc(5'h11, 8'h20, 8'h00, "line_alarm_flags");
		far_u.send(1'b1, 1, 2);
		rc(5'h11, 8'h20, 8'h20, "line_alarm_flags");
		$display("test density secondary done");
		slip_once(1'b1);
		rc(5'h13, 8'hC0, 8'hC0, "rx_slip_phase_upper");
		slip_once(1'b0);
		rc(5'h13, 8'hC0, 8'h00, "rx_slip_phase_upper");
		{depth, sub, slot, bitd} = {1'b1, 3'h5, 5'h15, 3'h3};
		far_u.send(1'b1, 400, 0);
		rc(5'h13, 8'h3F, 8'h25, "rx_slip_phase_upper");
		rc(5'h14, 8'hFF, 8'hAB, "rx_slip_phase_lower");
		slot = 5'h05;
		far_u.send(1'b1, 400, 0);
		rc(5'h13, 8'h08, 8'h08, "rx_slip_phase_upper");
		rc(5'h14, 8'hFF, 8'h2B, "rx_slip_phase_lower");
		$display("test slip phase done");
		low = 1'b1;
		repeat (30) @(posedge clk_sys_i);
		rc(5'h16, 8'hFF, 8'h80, "rx_line_signal_flags");
		low = 1'b0;
		repeat (10) @(posedge clk_sys_i);
		rc(5'h16, 8'hFF, 8'h00, "rx_line_signal_flags");
		$display("test signal loss done");
		repeat (32) begin
			far_u.send(1'b0, 4, 0);
			far_u.send(1'b1, 1, 0);
		end
		rc(5'h11, 8'h03, 8'h02, "line_alarm_flags");
		repeat (54) begin
			far_u.send(1'b0, 2, 0);
			far_u.send(1'b1, 1, 0);
		end
		rc(5'h11, 8'h03, 8'h01, "line_alarm_flags");
		$display("test loop codes done");
		far_u.send_word(16'h00FF, 6);
		rc(5'h11, 8'h10, 8'h00, "line_alarm_flags");
		far_u.send_word(16'h00FF, 1);
		rc(5'h11, 8'h10, 8'h10, "line_alarm_flags");
		far_u.send_word(16'hFF1E, 7);
		rc(5'h15, 8'hFF, 8'h00, "rx_message_codeword");
		far_u.send_word(16'hFF1E, 1);
		rc(5'h15, 8'hFF, 8'h1E, "rx_message_codeword");
		rc(5'h11, 8'h10, 8'h00, "line_alarm_flags");
		$display("test data link done");
		give_verdict();
	end
endmodule : testbench
